// File: design/dp_consts.vh
// Constants shared by the debug-port instruction layer files.
// Assumes plain Verilog-2005 and inclusion by bare name.
//
// Notes on behaviour
// - Control store: address in opcode, one byte.
// - Control store sends no acknowledge back.
// - Repeats skip sync and opcode frames.
// - The repeat instruction itself never repeats.
// - One count byte; count plus one runs.
// - Only a break aborts a running repeat.
// - Repeated indirect store keeps its acknowledge.
// - Key accepts 64 bits; size sets frames.
// - Info-block bit sends block, not key.
// - No key reply; block after guard time.
// - Two idle bits, or two more gap bits.
// - First byte after turnaround: guard time only.
// - Info block holds ASCII identification characters.
// - Fixed byte layout of the info block.
// - Three 64-bit signatures, low byte first.
// - Each key has its own clear events.
// - Erase key leaves programming key active.
// - Locked port refuses system-bus instructions.
// - Chip erase forces brown-out detector on.
// - Eight key bytes compared, status bit set.
`ifndef DP_CONSTS_VH
`define DP_CONSTS_VH

// =====================================================================
// Link framing and opcode fields
`define DP_SYNC_CHAR     8'h55
`define DP_OP_REPEAT     3'h5
`define DP_OP_CSSTORE    3'h6
`define DP_OP_KEY        3'h7
`define DP_OP_SIB_BIT    2
`define DP_KEYSZ_64      2'h0
`define DP_KEYSZ_128     2'h1
`define DP_KEY_BYTES     5'd8
`define DP_SIB_BYTES     5'd16
`define DP_IDLE_NORMAL   3'h2
`define DP_IDLE_GAP      3'h4
`define DP_IDLE_FIRST    3'h0

// =====================================================================
// Control/status space inside the port
`define DP_CS_KEY_STATUS 4'h7
`define DP_CS_RESET_REQ  4'h8
`define DP_CS_RESET_SIG  8'h59
`define DP_KEYBIT_UROW   5
`define DP_BOD_ACTIVE    2'h1

// =====================================================================
// Key signatures, least significant byte is received first
`define DP_SIG_ERASE     64'h4e564d4572617365
`define DP_SIG_NVPROG    64'h4e564d50726f6720
`define DP_SIG_UROW      64'h4e564d5573267465

// =====================================================================
// APB register map and fields
`define DP_A_CTRL        12'h000
`define DP_A_CMD         12'h004
`define DP_A_STATUS      12'h008
`define DP_CTRL_GAP      0
`define DP_CTRL_DIS      1
`define DP_CMD_PRST      0
`define DP_CMD_UROWCLR   1

`endif

// File: design/dp_core.v
// Instruction layer of the one-wire debug port: control store,
// repeat counter, key entry, info block readout and chip erase.
// Assumes a physical layer on pclk that hands over received bytes,
// flags breaks and sends bytes after its own guard time.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dp_consts.vh"

module dp_core (
  input  wire        pclk,          // System clock, 100 MHz.
  input  wire        presetn,       // Asynchronous reset, active low.
  input  wire        psel,          // APB select.
  input  wire        penable,       // APB access phase.
  input  wire        pwrite,        // APB direction.
  input  wire [11:0] paddr,         // APB byte address.
  input  wire [31:0] pwdata,        // APB write data.
  output wire [31:0] prdata,        // APB read data.
  output wire        pready,        // APB ready.
  output wire        pslverr,       // APB error on unmapped address.
  input  wire        rx_valid,      // Received byte strobe.
  input  wire [7:0]  rx_data,       // Received byte.
  input  wire        rx_break,      // Break character seen.
  input  wire        tx_ready,      // Physical layer took the byte.
  output wire        tx_valid,      // Byte to send.
  output wire [7:0]  tx_data,       // Data of that byte.
  output wire [2:0]  tx_idle_bits,  // Idle bits before it.
  output wire        tx_first,      // First byte after turnaround.
  output wire        cs_wr,         // Control store pulse.
  output wire [3:0]  cs_addr,       // Control store address.
  output wire [7:0]  cs_wdata,      // Control store data.
  output wire        bus_instr,     // Start a data-space instruction.
  output wire [7:0]  bus_opcode,    // Its opcode.
  output wire        bus_repeat,    // Iteration sent without opcode.
  input  wire        bus_done,      // Data-space instruction ended.
  input  wire        lock_bits,     // Device lock bits set.
  input  wire        erase_done,    // Chip erase finished.
  input  wire        prog_done,     // Programming finished.
  output wire        bus_grant,     // System bus access allowed.
  output wire [2:0]  key_state,     // Erase, programming, user row.
  output wire        sys_reset,     // System reset request.
  output wire        erase_req,     // Chip erase start pulse.
  output wire        bod_force,     // Brown-out detector forced on.
  output wire [1:0]  bod_mode,      // Forced detector mode.
  output wire        bod_lvl_fuse   // Use fuse threshold level.
);

  // ===================================================================
  // States
  localparam [2:0] S_SYNC   = 3'd0;  // Wait for sync character.
  localparam [2:0] S_OPC    = 3'd1;  // Wait for opcode.
  localparam [2:0] S_CS     = 3'd2;  // Control store data frame.
  localparam [2:0] S_RPT    = 3'd3;  // Repeat count frame.
  localparam [2:0] S_KEY    = 3'd4;  // Key frames.
  localparam [2:0] S_SIB_AD = 3'd5;  // Memory address settles.
  localparam [2:0] S_SIB_TX = 3'd6;  // Info block byte out.
  localparam [2:0] S_BUS    = 3'd7;  // Data-space instruction.

  // ===================================================================
  // Registers
  reg [2:0]   st_r;         // Instruction state.
  reg [7:0]   op_r;         // Opcode kept for repeats.
  reg [7:0]   rpt_r;        // Remaining repeats.
  reg [4:0]   idx_r;        // Frame index.
  reg [63:0]  key_sr_r;     // Key shift register.
  reg [2:0]   keys_r;       // Active keys.
  reg         gap_en_r;     // Byte gap option.
  reg         dis_r;        // Port disable.
  reg         sysrst_r;     // Reset request held.
  reg         busy_r;       // Chip erase running.
  reg         ereq_r;       // Erase start pulse.
  reg         grant_r;      // Bus access allowed.
  reg         txv_r;        // Transmit valid.
  reg [7:0]   txd_r;        // Transmit data.
  reg [2:0]   txi_r;        // Idle bits ahead.
  reg         txf_r;        // First byte flag.
  reg         csw_r;        // Control store pulse.
  reg [3:0]   csa_r;        // Control store address.
  reg [7:0]   csd_r;        // Control store data.
  reg         bi_r;         // Bus instruction pulse.
  reg         brep_r;       // Bus iteration is a repeat.
  reg [31:0]  prdata_r;     // Read data.
  reg         pready_r;     // Ready in access phase.
  reg         pslverr_r;    // Error in access phase.
  reg         prst_r;       // Port reset pulse from software.
  reg         urclr_r;      // User-row key clear from software.

  wire [2:0]  hit;          // Signature matches.
  wire [7:0]  sib_byte;     // Info block byte.

  // ===================================================================
  // Helpers
  // Frame count follows the size field; 16 for the long setting.
  function [4:0] frames;
    input [7:0] op;
    begin
      frames = (op[1:0] == `DP_KEYSZ_128) ? `DP_SIB_BYTES : `DP_KEY_BYTES;
    end
  endfunction

  // State where the data phase of an instruction starts.
  function [2:0] entry;
    input [7:0] op;
    begin
      if (op[7:5] == `DP_OP_CSSTORE)
        entry = S_CS;
      else if (op[7:5] == `DP_OP_KEY)
        entry = op[`DP_OP_SIB_BIT] ? S_SIB_AD : S_KEY;
      else
        entry = S_BUS;
    end
  endfunction

  // ===================================================================
  // Leaves
  dp_key_match u_match (
    .key ({rx_data, key_sr_r[63:8]}),  // Key as it stands with this byte.
    .hit (hit)
  );

  dp_sib_rom u_sib (
    .pclk  (pclk),
    .addr  (idx_r[3:0]),
    .rdata (sib_byte)
  );

  // ===================================================================
  // Instruction end
  // An instruction is over when its last frame moves. Control store
  // has no acknowledge, so the data byte itself ends it.
  wire last_frame = (idx_r == frames(op_r) - 5'd1);
  wire fin = (st_r == S_CS && rx_valid) ||
             (st_r == S_KEY && rx_valid && last_frame) ||
             (st_r == S_SIB_TX && txv_r && tx_ready && last_frame) ||
             (st_r == S_BUS && bus_done);

  // APB write strobe at the access edge.
  wire apb_wr = psel && penable && pready_r && pwrite;

  // Port reset comes only from the software command bit.
  wire port_rst = prst_r;

  // Control store towards the internal reset and key status registers.
  wire cs_hit = (st_r == S_CS) && rx_valid;
  wire rst_wr = cs_hit && (op_r[3:0] == `DP_CS_RESET_REQ);
  wire key_wr = cs_hit && (op_r[3:0] == `DP_CS_KEY_STATUS);

  // Each key bit has its own clear events. A key completing in the
  // same cycle still sets its bit, while the other clears go through.
  wire       key_done = (st_r == S_KEY) && rx_valid && last_frame &&
                        (op_r[1:0] == `DP_KEYSZ_64);
  wire [2:0] key_set  = key_done ? hit : 3'b000;
  wire [2:0] key_clr  = {port_rst || urclr_r ||
                         (key_wr && rx_data[`DP_KEYBIT_UROW]),
                         port_rst || prog_done,
                         port_rst || dis_r};

  // ===================================================================
  // Instruction sequencer
  // A break drops everything, the only way out of a repeat.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= S_SYNC;
      op_r     <= 8'h00;
      rpt_r    <= 8'h00;
      idx_r    <= 5'd0;
      key_sr_r <= 64'h0;
      txv_r    <= 1'b0;
      txd_r    <= 8'h00;
      txi_r    <= `DP_IDLE_FIRST;
      txf_r    <= 1'b0;
      csw_r    <= 1'b0;
      csa_r    <= 4'h0;
      csd_r    <= 8'h00;
      bi_r     <= 1'b0;
      brep_r   <= 1'b0;
    end else begin
      csw_r <= 1'b0;
      bi_r  <= 1'b0;
      if (rx_break) begin
        st_r  <= S_SYNC;
        rpt_r <= 8'h00;
        txv_r <= 1'b0;
      end else begin
        case (st_r)
          S_SYNC: begin
            if (rx_valid && rx_data == `DP_SYNC_CHAR)
              st_r <= S_OPC;
          end
          S_OPC: begin
            if (rx_valid) begin
              op_r  <= rx_data;
              idx_r <= 5'd0;
              if (rx_data[7:5] == `DP_OP_REPEAT) begin
                st_r <= S_RPT;
              end else if (!rx_data[7] && lock_bits) begin
                // Locked: system-bus instructions are dropped.
                st_r  <= S_SYNC;
                rpt_r <= 8'h00;
              end else begin
                st_r   <= entry(rx_data);
                bi_r   <= (entry(rx_data) == S_BUS);
                brep_r <= 1'b0;
              end
            end
          end
          S_CS: begin
            if (rx_valid) begin
              csw_r <= 1'b1;
              csa_r <= op_r[3:0];
              csd_r <= rx_data;
            end
          end
          S_RPT: begin
            if (rx_valid) begin
              // The count belongs to the next instruction only.
              rpt_r <= rx_data;
              st_r  <= S_SYNC;
            end
          end
          S_KEY: begin
            if (rx_valid) begin
              // Low byte first: shift new bytes in from the top.
              key_sr_r <= {rx_data, key_sr_r[63:8]};
              idx_r    <= idx_r + 5'd1;
            end
          end
          S_SIB_AD: begin
            // Memory output is valid one cycle after the address.
            st_r <= S_SIB_TX;
          end
          S_SIB_TX: begin
            if (!txv_r) begin
              txv_r <= 1'b1;
              txd_r <= sib_byte;
              txf_r <= (idx_r == 5'd0);
              // Turnaround byte waits guard time only; later bytes
              // get the normal or the widened gap.
              if (idx_r == 5'd0)
                txi_r <= `DP_IDLE_FIRST;
              else if (gap_en_r)
                txi_r <= `DP_IDLE_GAP;
              else
                txi_r <= `DP_IDLE_NORMAL;
            end else if (tx_ready) begin
              txv_r <= 1'b0;
              idx_r <= idx_r + 5'd1;
              st_r  <= S_SIB_AD;
            end
          end
          S_BUS: begin
            // Waits for the data-space executor to finish.
          end
          default: begin
            st_r <= S_SYNC;
          end
        endcase
        // Each finished instruction either runs again without sync
        // and opcode or returns to waiting for sync.
        if (fin) begin
          idx_r <= 5'd0;
          if (rpt_r != 8'h00) begin
            rpt_r  <= rpt_r - 8'h01;
            st_r   <= entry(op_r);
            bi_r   <= (entry(op_r) == S_BUS);
            brep_r <= 1'b1;
          end else begin
            st_r <= S_SYNC;
          end
        end
      end
    end
  end

  // ===================================================================
  // Keys, reset request and chip erase
  // Clears and sets are merged, so a set wins only on its own bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_r   <= 3'b000;
      sysrst_r <= 1'b0;
      busy_r   <= 1'b0;
      ereq_r   <= 1'b0;
      grant_r  <= 1'b0;
    end else begin
      ereq_r  <= 1'b0;
      grant_r <= !lock_bits;
      // A complete 64-bit key sets only its own bit; others stay.
      keys_r <= (keys_r & ~key_clr) | key_set;
      // Erase end first, so an erase start in the same cycle wins.
      if (erase_done)
        busy_r <= 1'b0;
      // Reset held by the signature, released by a zero write.
      if (rst_wr && rx_data == `DP_CS_RESET_SIG) begin
        sysrst_r <= 1'b1;
      end else if (rst_wr && rx_data == 8'h00 && sysrst_r) begin
        sysrst_r <= 1'b0;
        if (keys_r[0]) begin
          busy_r <= 1'b1;
          ereq_r <= 1'b1;
        end
      end
    end
  end

  // ===================================================================
  // APB slave
  // Zero-wait: ready is raised for the access phase of every transfer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      gap_en_r  <= 1'b0;
      dis_r     <= 1'b0;
      prst_r    <= 1'b0;
      urclr_r   <= 1'b0;
    end else begin
      prst_r  <= 1'b0;
      urclr_r <= 1'b0;
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !(paddr == `DP_A_CTRL || paddr == `DP_A_CMD ||
                       paddr == `DP_A_STATUS);
        case (paddr)
          `DP_A_CTRL:
            prdata_r <= {30'h0, dis_r, gap_en_r};
          `DP_A_STATUS:
            prdata_r <= {16'h0, rpt_r, 1'b0, (rpt_r != 8'h00),
                         sysrst_r, busy_r, lock_bits, keys_r};
          default:
            prdata_r <= 32'h0;
        endcase
      end
      if (apb_wr && paddr == `DP_A_CTRL) begin
        gap_en_r <= pwdata[`DP_CTRL_GAP];
        dis_r    <= pwdata[`DP_CTRL_DIS];
      end
      if (apb_wr && paddr == `DP_A_CMD) begin
        prst_r  <= pwdata[`DP_CMD_PRST];
        urclr_r <= pwdata[`DP_CMD_UROWCLR];
      end
    end
  end

  // ===================================================================
  // Outputs, all from flip-flops
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign tx_valid     = txv_r;
  assign tx_data      = txd_r;
  assign tx_idle_bits = txi_r;
  assign tx_first     = txf_r;
  assign cs_wr        = csw_r;
  assign cs_addr      = csa_r;
  assign cs_wdata     = csd_r;
  assign bus_instr    = bi_r;
  assign bus_opcode   = op_r;
  assign bus_repeat   = brep_r;
  assign bus_grant    = grant_r;
  assign key_state    = keys_r;
  assign sys_reset    = sysrst_r;
  assign erase_req    = ereq_r;
  // While the erase runs the detector is forced on at fuse level.
  assign bod_force    = busy_r;
  assign bod_mode     = busy_r ? `DP_BOD_ACTIVE : 2'h0;
  assign bod_lvl_fuse = busy_r;

endmodule

// File: design/dp_key_match.v
// Signature comparator for the 64-bit activation keys.
// Assumes the key is assembled with the first received byte lowest.
`timescale 1ns/1ps
`include "dp_consts.vh"

// =====================================================================
// Key comparator
module dp_key_match (
  input  wire [63:0] key,   // Assembled key bytes.
  output wire [2:0]  hit    // One-hot: erase, programming, user row.
);
  // Each signature gets a plain equality; no match gives all zero.
  assign hit[0] = (key == `DP_SIG_ERASE);
  assign hit[1] = (key == `DP_SIG_NVPROG);
  assign hit[2] = (key == `DP_SIG_UROW);
endmodule

// File: design/dp_sib_rom.v
// Read-only store of the 16-byte system information block.
// Assumes one read per cycle; data come out of a register.
`timescale 1ns/1ps
`include "dp_consts.vh"

// =====================================================================
// Information block memory
module dp_sib_rom #(
  // Bytes 6..0 family, 7 reserved, 10..8 memory rev, 13..11 debug rev,
  // 14 reserved, 15 debug oscillator rate. Value is arbitrary ASCII.
  parameter [127:0] CONTENT = 128'h33_20_31_30_30_20_30_30_30_20_58_58_58_58_58_58
) (
  input  wire       pclk,   // System clock.
  input  wire [3:0] addr,   // Byte index.
  output reg  [7:0] rdata   // Registered byte.
);
  // Registered read keeps the output free of decode glitches.
  always @(posedge pclk) begin
    rdata <= CONTENT[{addr, 3'b000} +: 8];
  end
endmodule

// File: tb/debug_port_repeat_key_erase_tb_top.sv
// Self-checking bench for the debug-port instruction layer.
// Assumes dp_core, the partner model and the checker are compiled.
`timescale 1ns/1ps
module debug_port_repeat_key_erase_tb_top;
  localparam [127:0] SIB =
    128'h33_20_31_30_30_20_30_30_30_20_58_58_58_58_58_58;
  localparam [63:0] K_ER = 64'h4e564d4572617365;
  localparam [63:0] K_NV = 64'h4e564d50726f6720;
  localparam [63:0] K_UR = 64'h4e564d5573267465;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic rx_valid, rx_break, tx_ready, tx_valid, tx_first, cs_wr;
  logic bus_instr, bus_repeat, bus_done, lock_bits, erase_done;
  logic prog_done, bus_grant, sys_reset, erase_req, bod_force, bod_lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [7:0]  rx_data, tx_data, bus_opcode, cs_wdata, cnt;
  logic [2:0]  tx_idle_bits, key_state;
  logic [3:0]  cs_addr;
  logic [1:0]  bod_mode;
  logic        err;
  int fail_count, n_compared, cyc, nb, nr;
  dp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_break(rx_break),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_idle_bits(tx_idle_bits), .tx_first(tx_first), .cs_wr(cs_wr),
    .cs_addr(cs_addr), .cs_wdata(cs_wdata), .bus_instr(bus_instr),
    .bus_opcode(bus_opcode), .bus_repeat(bus_repeat),
    .bus_done(bus_done), .lock_bits(lock_bits), .erase_done(erase_done),
    .prog_done(prog_done), .bus_grant(bus_grant), .key_state(key_state),
    .sys_reset(sys_reset), .erase_req(erase_req), .bod_force(bod_force),
    .bod_mode(bod_mode), .bod_lvl_fuse(bod_lvl));
  dp_phy_model phy (.pclk(pclk), .presetn(presetn), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_idle_bits(tx_idle_bits),
    .tx_first(tx_first), .tx_ready(tx_ready), .bus_instr(bus_instr),
    .bus_repeat(bus_repeat), .bus_done(bus_done));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task st(input logic [31:0] exp);
    apb(1'b0, 12'h008, 32'h0);
    chk(q & 32'h7f, exp);
  endtask
  task rxb(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge pclk);
    rx_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task key(input logic [63:0] k);
    rxb(8'h55);
    rxb(8'he0);
    for (int i = 0; i < 8; i++) rxb(k[8*i +: 8]);
  endtask
  task sib(input logic [7:0] op, input int n, input logic [2:0] gap);
    rxb(8'h55);
    rxb(op);
    while (phy.n_tx[3:0] != n[3:0] || !phy.n_tx) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      chk(phy.byte_r[i], SIB[8*i +: 8]);
      chk(phy.idle_r[i], i ? gap : 3'h0);
      chk(phy.first_r[i], i == 0);
    end
  endtask
  // Free-running clock; the timeout counter cuts a hang short.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_valid, rx_break, slow} = 7'h0;
    {erase_done, prog_done, paddr, pwdata, rx_data} = 54'h0;
    lock_bits = 1'b1;
    seed = 32'hb8caebe5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    st(32'h08);
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1);
    rxb(8'h55);
    rxb(8'h64);
    repeat (8) @(posedge pclk);
    chk(phy.n_bus, 0);
    seed = lfsr(seed);
    key({seed, lfsr(seed)});
    st(32'h08);
    key(K_NV);
    key(K_ER);
    st(32'h0b);
    key(K_UR);
    st(32'h0f);
    rxb(8'h55); rxb(8'hc7); rxb(8'h20);
    st(32'h0b);
    rxb(8'h55); rxb(8'hc8); rxb(8'h59);
    st(32'h2b);
    rxb(8'h55); rxb(8'hc8); rxb(8'h00);
    st(32'h1b);
    erase_done <= 1'b1;
    lock_bits <= 1'b0;
    @(posedge pclk);
    erase_done <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(q[4:3], 2'b00);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h000, 32'h0);
    prog_done <= 1'b1;
    @(posedge pclk);
    prog_done <= 1'b0;
    st(32'h00);
    key(K_ER);
    apb(1'b1, 12'h004, 32'h1);
    st(32'h00);
    chk(phy.n_tx, 0);
    slow <= 1'b1;
    sib(8'he5, 16, 3'h2);
    apb(1'b1, 12'h000, 32'h1);
    sib(8'he4, 8, 3'h4);
    for (int r = 0; r < 2; r++) begin
      seed = lfsr(seed);
      cnt = r ? 8'hff : {6'h0, seed[1:0]} + 8'h1;
      nb = phy.n_bus;
      nr = phy.n_rep;
      rxb(8'h55); rxb(8'ha0); rxb(cnt);
      rxb(8'h55); rxb(8'h64);
      repeat (60) @(posedge pclk);
      if (r) begin
        rx_break <= 1'b1;
        @(posedge pclk);
        rx_break <= 1'b0;
        repeat (8) @(posedge pclk);
        nb = phy.n_bus;
        repeat (40) @(posedge pclk);
        chk(phy.n_bus, nb);
      end else begin
        chk(phy.n_bus - nb, cnt + 1);
        chk(phy.n_rep - nr, cnt);
      end
      st(32'h00);
    end
    chk(bus_opcode, 8'h64);
    wrap_up;
  end
endmodule

// File: tb/dp_core_properties.sv
// Assertions on the ports of the debug-port instruction layer.
// Assumes it is bound to dp_core and sees only that module's ports.
`timescale 1ns/1ps
// =====================================================================
// Checker
module dp_core_props (
  input logic       pclk,
  input logic       presetn,
  input logic       rx_valid,
  input logic [7:0] rx_data,
  input logic       tx_valid,
  input logic       tx_ready,
  input logic [7:0] tx_data,
  input logic [2:0] tx_idle_bits,
  input logic       tx_first,
  input logic       cs_wr,
  input logic [3:0] cs_addr,
  input logic [7:0] cs_wdata,
  input logic       bus_instr,
  input logic       bus_grant,
  input logic [2:0] key_state,
  input logic       erase_req,
  input logic       bod_force,
  input logic [1:0] bod_mode,
  input logic       bod_lvl_fuse
);
  logic [7:0] prev_rx_r;  // Last frame, to spot two-frame headers.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Keep the previous frame; headers span two received bytes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prev_rx_r <= 8'h00;
    else if (rx_valid)
      prev_rx_r <= rx_data;
  end
  sequence s_sib_req;
    rx_valid && rx_data == 8'he5 && prev_rx_r == 8'h55;
  endsequence
  sequence s_sib_out;
    tx_valid && tx_first && tx_idle_bits == 3'h0;
  endsequence
  sequence s_rst_store;
    rx_valid && rx_data == 8'h59 && prev_rx_r == 8'hc8;
  endsequence
  AST_CS_FRAME: assert property (
    s_rst_store |-> ##[1:2] (cs_wr && cs_addr == 4'h8 && cs_wdata == 8'h59))
    else $error("Control store frame lost.");
  AST_CS_QUIET: assert property (cs_wr |=> !tx_valid [*4])
    else $error("Control store produced a reply.");
  AST_KEY_QUIET: assert property (
    (key_state & ~$past(key_state)) != 3'h0 |-> !tx_valid)
    else $error("Key entry produced a reply.");
  AST_SIB_START: assert property (s_sib_req |-> ##[1:3] s_sib_out)
    else $error("Info block did not start.");
  AST_FIRST_GAP: assert property (
    tx_valid && tx_first |-> tx_idle_bits == 3'h0)
    else $error("First byte carries extra idle bits.");
  AST_NEXT_GAP: assert property (
    tx_valid && !tx_first |-> tx_idle_bits inside {3'h2, 3'h4})
    else $error("Wrong idle bits between bytes.");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Offered byte changed before taken.");
  AST_LOCK_BUS: assert property (bus_instr |-> bus_grant)
    else $error("Bus instruction while locked.");
  AST_ERASE_KEY: assert property (erase_req |-> $past(key_state[0]))
    else $error("Erase without its key.");
  AST_ERASE_BOD: assert property (
    erase_req |-> ##[0:1] (bod_force && bod_mode == 2'h1 && bod_lvl_fuse))
    else $error("Detector not forced during erase.");
endmodule
bind dp_core dp_core_props u_props (.pclk(pclk), .presetn(presetn),
  .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_idle_bits(tx_idle_bits),
  .tx_first(tx_first), .cs_wr(cs_wr), .cs_addr(cs_addr),
  .cs_wdata(cs_wdata), .bus_instr(bus_instr), .bus_grant(bus_grant),
  .key_state(key_state), .erase_req(erase_req), .bod_force(bod_force),
  .bod_mode(bod_mode), .bod_lvl_fuse(bod_lvl_fuse));

// File: tb/dp_phy_model.sv
// Model of the link layer and the data-space executor beside dp_core.
// Assumes one clock; logs each byte the port sends for the bench.
`timescale 1ns/1ps
// =====================================================================
// Partner
module dp_phy_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       slow,          // Take a byte every other cycle.
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  input  logic [2:0] tx_idle_bits,
  input  logic       tx_first,
  output logic       tx_ready,
  input  logic       bus_instr,
  input  logic       bus_repeat,
  output logic       bus_done
);
  logic [7:0]  byte_r [0:15];  // Bytes taken from the port.
  logic [2:0]  idle_r [0:15];  // Idle bits asked before each.
  logic [15:0] first_r;        // Turnaround flag of each.
  int          n_tx;           // Bytes taken so far.
  int          n_bus;          // Executor starts seen.
  int          n_rep;          // Of those, repeat iterations.
  logic        tog_r;          // Stall phase.
  logic [1:0]  done_r;         // Executor latency line.
  // A slow debugger stalls; the port must hold its byte meanwhile.
  assign tx_ready = !slow || tog_r;
  assign bus_done = done_r[1];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_r  <= 1'b0;
      done_r <= 2'b00;
      n_tx   <= 0;
      n_bus  <= 0;
      n_rep  <= 0;
    end else begin
      tog_r  <= !tog_r;
      done_r <= {done_r[0], bus_instr};
      n_bus  <= n_bus + int'(bus_instr);
      n_rep  <= n_rep + int'(bus_instr && bus_repeat);
      if (tx_valid && tx_ready) begin
        byte_r[n_tx[3:0]]  <= tx_data;
        idle_r[n_tx[3:0]]  <= tx_idle_bits;
        first_r[n_tx[3:0]] <= tx_first;
        n_tx <= n_tx + 1;
      end
    end
  end
endmodule
